//--- include/local_share_pkg.sv
// Constants shared by the local share atomic unit and its helpers
package local_share_pkg;
  // Data and array geometry
  localparam int DATA_W = 32;
  localparam int ADDR_W = 10;
  localparam int DEPTH  = 1024;
  // Issue fields from the clause sequencer
  localparam int SLOT_W  = 3;
  localparam int OPC_W   = 5;
  localparam int SEL_W   = 6;
  localparam int BASE_W  = 5;
  localparam int RET_BIT = 5;
  localparam int OFS_W   = 6;
  // Element slot that may carry an indexed access (x)
  localparam logic [SLOT_W-1:0] SLOT_X         = 3'h0;
  // Arithmetic opcode value that selects an indexed share access (17)
  localparam logic [OPC_W-1:0]  SHARE_IDX_OPC  = 5'h11;
  // Paired forms scale the index offset by 64
  localparam int PAIR_SHIFT = 6;
  // Base operation codes in the low five bits of the select field
  localparam logic [BASE_W-1:0] OP_ADD         = 5'h00;
  localparam logic [BASE_W-1:0] OP_SUB         = 5'h01;
  localparam logic [BASE_W-1:0] OP_RSUB        = 5'h02;
  localparam logic [BASE_W-1:0] OP_INC         = 5'h03;
  localparam logic [BASE_W-1:0] OP_DEC         = 5'h04;
  localparam logic [BASE_W-1:0] OP_MIN_INT     = 5'h05;
  localparam logic [BASE_W-1:0] OP_MAX_INT     = 5'h06;
  localparam logic [BASE_W-1:0] OP_MIN_UINT    = 5'h07;
  localparam logic [BASE_W-1:0] OP_MAX_UINT    = 5'h08;
  localparam logic [BASE_W-1:0] OP_AND         = 5'h09;
  localparam logic [BASE_W-1:0] OP_OR          = 5'h0a;
  localparam logic [BASE_W-1:0] OP_XOR         = 5'h0b;
  localparam logic [BASE_W-1:0] OP_MSKOR       = 5'h0c;
  localparam logic [BASE_W-1:0] OP_WRITE       = 5'h0d;
  localparam logic [BASE_W-1:0] OP_XCHG        = 5'h0e;
  localparam logic [BASE_W-1:0] OP_CMP_STORE   = 5'h0f;
  localparam logic [BASE_W-1:0] OP_BYTE_WRITE  = 5'h10;
  localparam logic [BASE_W-1:0] OP_SHORT_WRITE = 5'h11;
  localparam logic [BASE_W-1:0] OP_READ        = 5'h12;
  localparam logic [BASE_W-1:0] OP_SHORT_READ  = 5'h13;
  localparam logic [BASE_W-1:0] OP_USHORT_READ = 5'h14;
  localparam logic [BASE_W-1:0] OP_BYTE_READ   = 5'h15;
  localparam logic [BASE_W-1:0] OP_UBYTE_READ  = 5'h16;
  localparam logic [BASE_W-1:0] OP_DUAL_READ   = 5'h17;
  localparam logic [BASE_W-1:0] OP_REL_READ    = 5'h18;
  localparam logic [BASE_W-1:0] OP_PAIR_XCHG   = 5'h19;
  localparam logic [BASE_W-1:0] OP_REL_XCHG    = 5'h1a;
  localparam logic [BASE_W-1:0] OP_READ_WRITE  = 5'h1b;
  localparam logic [BASE_W-1:0] OP_PAIR_WRITE  = 5'h1c;
  localparam logic [BASE_W-1:0] OP_REL_WRITE   = 5'h1d;
  localparam logic [BASE_W-1:0] OP_ORDER_ALLOC = 5'h1e;
  // Reset value and the increment and decrement step
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [DATA_W-1:0] WORD_ONE  = 32'h0000_0001;
endpackage

//--- rtl/share_memory_array.sv
// Local shared memory word array, one write and one registered read port
`timescale 1ns/10ps
module share_memory_array (
  // Clock and reset
  input  wire logic                                 clk_sys_in,
  input  wire logic                                 rstn_in,
  // Write port
  input  wire logic                                 we_in,
  input  wire logic [local_share_pkg::ADDR_W-1:0]   waddr_in,
  input  wire logic [local_share_pkg::DATA_W-1:0]   wdata_in,
  // Read port, data one cycle after the address
  input  wire logic [local_share_pkg::ADDR_W-1:0]   raddr_in,
  output logic      [local_share_pkg::DATA_W-1:0]   rdata_out
);
  import local_share_pkg::*;

  logic [DATA_W-1:0] words [DEPTH];

  // Array write; contents are not cleared by reset
  always_ff @(posedge clk_sys_in) begin
    if (we_in) begin
      words[waddr_in] <= wdata_in;
    end
  end

  // Read returns the word as it stood before a same-edge write
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      rdata_out <= WORD_ZERO;
    end else begin
      rdata_out <= words[raddr_in];
    end
  end
endmodule

//--- rtl/share_atomic_alu.sv
// Update and return-value arithmetic for one shared memory word
`timescale 1ns/10ps
module share_atomic_alu (
  // Operation and operands
  input  wire logic [local_share_pkg::BASE_W-1:0] base_op_in,
  input  wire logic [local_share_pkg::DATA_W-1:0] stored_in,
  input  wire logic [local_share_pkg::DATA_W-1:0] src_in,
  input  wire logic [local_share_pkg::DATA_W-1:0] aux_in,
  // Results
  output logic      [local_share_pkg::DATA_W-1:0] new_word_out,
  output logic                                    write_out,
  output logic      [local_share_pkg::DATA_W-1:0] ret_word_out
);
  import local_share_pkg::*;

  // New word for the first address
  always_comb begin
    new_word_out = src_in;
    write_out    = 1'b1;
    unique case (base_op_in)
      OP_ADD:         new_word_out = stored_in + src_in;
      OP_SUB:         new_word_out = stored_in - src_in;
      OP_RSUB:        new_word_out = src_in - stored_in;
      OP_INC:         new_word_out = (stored_in >= src_in) ? WORD_ZERO : stored_in + WORD_ONE;
      OP_DEC:         new_word_out = (stored_in == WORD_ZERO || stored_in > src_in) ?
                                     src_in : stored_in - WORD_ONE;
      OP_MIN_INT:     new_word_out = ($signed(stored_in) < $signed(src_in)) ? stored_in : src_in;
      OP_MAX_INT:     new_word_out = ($signed(stored_in) > $signed(src_in)) ? stored_in : src_in;
      OP_MIN_UINT:    new_word_out = (stored_in < src_in) ? stored_in : src_in;
      OP_MAX_UINT:    new_word_out = (stored_in > src_in) ? stored_in : src_in;
      OP_AND:         new_word_out = stored_in & src_in;
      OP_OR:          new_word_out = stored_in | src_in;
      OP_XOR:         new_word_out = stored_in ^ src_in;
      OP_MSKOR:       new_word_out = (stored_in & ~aux_in) | src_in;
      OP_CMP_STORE:   new_word_out = (stored_in == aux_in) ? src_in : stored_in;
      OP_BYTE_WRITE:  new_word_out = {24'h00_0000, src_in[7:0]};
      OP_SHORT_WRITE: new_word_out = {16'h0000, src_in[15:0]};
      OP_WRITE, OP_XCHG, OP_PAIR_XCHG, OP_REL_XCHG, OP_PAIR_WRITE, OP_REL_WRITE: begin
        new_word_out = src_in;
      end
      default: begin
        new_word_out = stored_in;
        write_out    = 1'b0;
      end
    endcase
  end

  // Value for return queue A: extended read or the pre-update word
  always_comb begin
    unique case (base_op_in)
      OP_SHORT_READ:  ret_word_out = {{16{stored_in[15]}}, stored_in[15:0]};
      OP_USHORT_READ: ret_word_out = {16'h0000, stored_in[15:0]};
      OP_BYTE_READ:   ret_word_out = {{24{stored_in[7]}}, stored_in[7:0]};
      OP_UBYTE_READ:  ret_word_out = {24'h00_0000, stored_in[7:0]};
      default:        ret_word_out = stored_in;
    endcase
  end
endmodule

//--- rtl/local_share_atomic_unit.sv
// Indexed local shared memory access unit: atomics, writes, exchanges, reads
//
// Contract
// - Indexed share accesses are accepted only in the x element slot.
// - The issue supplies the first address; the unit derives relative and paired second addresses.
// - Arithmetic opcode 17 makes the select field name a share operation.
// - Compare-store writes the source only when the word equals the compare.
// - Wrapping decrement loads source if word is zero or above it, else subtracts one.
// - Wrapping increment clears when word is at or above source, else adds one.
// - Min and max keep the smaller or larger, signed and unsigned.
// - Masked OR clears the masked bits then ORs in the source.
// - Reverse subtract stores source minus word.
// - Subtract stores word minus source.
// - Signed half-word read returns bits 15 to 0 sign-extended in queue A.
// - Dual read returns first address in queue A, second in queue B.
// - Relative read adds index offset for the second address; both words return.
// - Paired exchange writes second source at base plus offset times 64.
// - Relative exchange writes second source at base plus plain offset.
// - Read-write returns the first address word and writes data at second.
// - Paired and relative writes store both sources at base and derived address.
`timescale 1ns/10ps
module local_share_atomic_unit (
  // Clock and reset
  input  wire logic                                 clk_sys_in,
  input  wire logic                                 rstn_in,
  // Issue from the clause sequencer
  input  wire logic                                 issue_valid_in,
  input  wire logic [local_share_pkg::SLOT_W-1:0]   element_slot_in,
  input  wire logic [local_share_pkg::OPC_W-1:0]    arith_opcode_field_in,
  input  wire logic [local_share_pkg::SEL_W-1:0]    share_operation_select_in,
  input  wire logic [local_share_pkg::ADDR_W-1:0]   addr_first_in,
  input  wire logic [local_share_pkg::ADDR_W-1:0]   addr_second_in,
  input  wire logic [local_share_pkg::OFS_W-1:0]    index_offset_in,
  input  wire logic [local_share_pkg::DATA_W-1:0]   src_first_in,
  input  wire logic [local_share_pkg::DATA_W-1:0]   src_second_in,
  // Status
  output logic                                      ready_out,
  output logic                                      reject_out,
  // Return queues
  output logic                                      return_queue_a_valid_out,
  output logic      [local_share_pkg::DATA_W-1:0]   return_queue_a_data_out,
  output logic                                      return_queue_b_valid_out,
  output logic      [local_share_pkg::DATA_W-1:0]   return_queue_b_data_out
);
  import local_share_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_UPDATE = 3'b010,
    ST_SECOND = 3'b100
  } state_t;

  state_t              state;
  state_t              next_state;
  logic [SEL_W-1:0]    op;
  logic [SEL_W-1:0]    next_op;
  logic [ADDR_W-1:0]   addr_a;
  logic [ADDR_W-1:0]   next_addr_a;
  logic [ADDR_W-1:0]   addr_b;
  logic [ADDR_W-1:0]   next_addr_b;
  logic [DATA_W-1:0]   src_a;
  logic [DATA_W-1:0]   next_src_a;
  logic [DATA_W-1:0]   src_b;
  logic [DATA_W-1:0]   next_src_b;
  logic                next_ready;
  logic                next_reject;
  logic                next_qa_valid;
  logic [DATA_W-1:0]   next_qa_data;
  logic                next_qb_valid;
  logic [DATA_W-1:0]   next_qb_data;
  logic                mem_we;
  logic [ADDR_W-1:0]   mem_waddr;
  logic [DATA_W-1:0]   mem_wdata;
  logic [ADDR_W-1:0]   mem_raddr;
  logic [DATA_W-1:0]   mem_rdata;
  logic [DATA_W-1:0]   alu_new;
  logic                alu_write;
  logic [DATA_W-1:0]   alu_ret;
  logic [BASE_W-1:0]   base;
  logic                issue_legal;

  // Issue is legal only in slot x, with opcode 17 and a defined local operation
  function automatic logic legal_issue(input logic [SLOT_W-1:0] slot,
                                       input logic [OPC_W-1:0]  opc,
                                       input logic [SEL_W-1:0]  sel);
    logic [BASE_W-1:0] b;
    b = sel[BASE_W-1:0];
    legal_issue = (slot == SLOT_X) && (opc == SHARE_IDX_OPC) &&
                  (b < OP_ORDER_ALLOC);
  endfunction

  // Second address of the two-address forms
  function automatic logic [ADDR_W-1:0] second_addr(input logic [BASE_W-1:0] b,
                                                    input logic [ADDR_W-1:0] a0,
                                                    input logic [ADDR_W-1:0] a1,
                                                    input logic [OFS_W-1:0]  ofs);
    unique case (b)
      OP_DUAL_READ, OP_READ_WRITE:           second_addr = a1;
      OP_REL_READ, OP_REL_XCHG, OP_REL_WRITE: second_addr = a0 + ADDR_W'(ofs);
      OP_PAIR_XCHG, OP_PAIR_WRITE:          second_addr = a0 + (ADDR_W'(ofs) << PAIR_SHIFT);
      default:                              second_addr = a0;
    endcase
  endfunction

  // Forms that need a second memory step
  function automatic logic two_step(input logic [BASE_W-1:0] b);
    two_step = (b == OP_DUAL_READ) || (b == OP_REL_READ) || (b == OP_PAIR_XCHG) ||
               (b == OP_REL_XCHG) || (b == OP_READ_WRITE) || (b == OP_PAIR_WRITE) ||
               (b == OP_REL_WRITE);
  endfunction

  // Forms whose second step returns a word in queue B
  function automatic logic reads_second(input logic [BASE_W-1:0] b);
    reads_second = (b == OP_DUAL_READ) || (b == OP_REL_READ);
  endfunction

  // Forms that deliver a word to queue A
  function automatic logic returns_a(input logic [SEL_W-1:0] sel);
    logic [BASE_W-1:0] b;
    b = sel[BASE_W-1:0];
    returns_a = sel[RET_BIT] || ((b >= OP_READ) && (b <= OP_READ_WRITE));
  endfunction

  assign base        = op[BASE_W-1:0];
  assign issue_legal = legal_issue(element_slot_in, arith_opcode_field_in, share_operation_select_in);

  // Word array
  share_memory_array u_array (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .we_in      (mem_we),
    .waddr_in   (mem_waddr),
    .wdata_in   (mem_wdata),
    .raddr_in   (mem_raddr),
    .rdata_out  (mem_rdata)
  );

  // Update arithmetic on the word read for the first address
  share_atomic_alu u_alu (
    .base_op_in   (base),
    .stored_in    (mem_rdata),
    .src_in       (src_a),
    .aux_in       (src_b),
    .new_word_out (alu_new),
    .write_out    (alu_write),
    .ret_word_out (alu_ret)
  );

  // Sequencer: read, update and second step; no issue taken while busy
  always_comb begin
    next_state    = state;
    next_op       = op;
    next_addr_a   = addr_a;
    next_addr_b   = addr_b;
    next_src_a    = src_a;
    next_src_b    = src_b;
    next_ready    = ready_out;
    next_reject   = 1'b0;
    next_qa_valid = 1'b0;
    next_qa_data  = return_queue_a_data_out;
    next_qb_valid = 1'b0;
    next_qb_data  = return_queue_b_data_out;
    mem_we        = 1'b0;
    mem_waddr     = addr_a;
    mem_wdata     = alu_new;
    mem_raddr     = addr_a;
    unique case (state)
      ST_IDLE: begin
        mem_raddr = addr_first_in;
        if (issue_valid_in) begin
          if (issue_legal) begin
            next_op     = share_operation_select_in;
            next_addr_a = addr_first_in;
            next_addr_b = second_addr(share_operation_select_in[BASE_W-1:0],
                                      addr_first_in, addr_second_in, index_offset_in);
            next_src_a  = src_first_in;
            next_src_b  = src_second_in;
            next_ready  = 1'b0;
            next_state  = ST_UPDATE;
          end else begin
            next_reject = 1'b1;
          end
        end
      end
      ST_UPDATE: begin
        mem_we    = alu_write;
        mem_raddr = addr_b;
        if (returns_a(op)) begin
          next_qa_valid = 1'b1;
          next_qa_data  = alu_ret;
        end
        if (two_step(base)) begin
          next_state = ST_SECOND;
        end else begin
          next_state = ST_IDLE;
          next_ready = 1'b1;
        end
      end
      ST_SECOND: begin
        mem_raddr = addr_b;
        if (!reads_second(base)) begin
          mem_we    = 1'b1;
          mem_waddr = addr_b;
          mem_wdata = (base == OP_READ_WRITE) ? src_a : src_b;
        end else begin
          next_qb_valid = 1'b1;
          next_qb_data  = mem_rdata;
        end
        next_state = ST_IDLE;
        next_ready = 1'b1;
      end
    endcase
  end

  // Sequencer and output registers
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state                    <= ST_IDLE;
      op                       <= {SEL_W{1'b0}};
      addr_a                   <= {ADDR_W{1'b0}};
      addr_b                   <= {ADDR_W{1'b0}};
      src_a                    <= WORD_ZERO;
      src_b                    <= WORD_ZERO;
      ready_out                <= 1'b1;
      reject_out               <= 1'b0;
      return_queue_a_valid_out <= 1'b0;
      return_queue_a_data_out  <= WORD_ZERO;
      return_queue_b_valid_out <= 1'b0;
      return_queue_b_data_out  <= WORD_ZERO;
    end else begin
      state                    <= next_state;
      op                       <= next_op;
      addr_a                   <= next_addr_a;
      addr_b                   <= next_addr_b;
      src_a                    <= next_src_a;
      src_b                    <= next_src_b;
      ready_out                <= next_ready;
      reject_out               <= next_reject;
      return_queue_a_valid_out <= next_qa_valid;
      return_queue_a_data_out  <= next_qa_data;
      return_queue_b_valid_out <= next_qb_valid;
      return_queue_b_data_out  <= next_qb_data;
    end
  end

  // Checks on issue, timing and arithmetic
  logic [BASE_W-1:0] issue_base;
  logic [ADDR_W-1:0] pair_target;
  logic [ADDR_W-1:0] rel_target;
  assign issue_base  = share_operation_select_in[BASE_W-1:0];
  assign pair_target = addr_first_in + (ADDR_W'(index_offset_in) << PAIR_SHIFT);
  assign rel_target  = addr_first_in + ADDR_W'(index_offset_in);

  sequence s_taken;
    (state == ST_IDLE) && issue_valid_in && issue_legal;
  endsequence

  sequence s_update_done;
    ##1 (state == ST_UPDATE) ##1 (state == ST_SECOND);
  endsequence

  property p_slot_x;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (state == ST_IDLE) && issue_valid_in && (element_slot_in != SLOT_X) |=> reject_out && ready_out;
  endproperty
  a_slot_x: assert property (p_slot_x) else $error("issue outside slot x not rejected");

  property p_opcode;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (state == ST_IDLE) && issue_valid_in && (arith_opcode_field_in != SHARE_IDX_OPC) |=> reject_out;
  endproperty
  a_opcode: assert property (p_opcode) else $error("foreign opcode not rejected");

  property p_atomic_busy;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    s_taken |=> !ready_out ##[1:2] ready_out;
  endproperty
  a_atomic_busy: assert property (p_atomic_busy) else $error("busy window wrong");

  property p_queue_a;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    s_taken ##0 returns_a(share_operation_select_in) |-> ##2 return_queue_a_valid_out;
  endproperty
  a_queue_a: assert property (p_queue_a) else $error("queue A answer missing");

  property p_queue_b;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    s_taken ##0 reads_second(issue_base) |-> s_update_done ##1 return_queue_b_valid_out;
  endproperty
  a_queue_b: assert property (p_queue_b) else $error("queue B answer missing");

  property p_short_sign;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    return_queue_a_valid_out && (base == OP_SHORT_READ) |->
      return_queue_a_data_out[31:16] == {16{return_queue_a_data_out[15]}};
  endproperty
  a_short_sign: assert property (p_short_sign) else $error("half-word read not sign-extended");

  property p_subtract;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (state == ST_UPDATE) && (base == OP_SUB) |-> mem_we && (mem_wdata == mem_rdata - src_a);
  endproperty
  a_subtract: assert property (p_subtract) else $error("subtract result wrong");

  property p_increment;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (state == ST_UPDATE) && (base == OP_INC) |->
      mem_wdata == ((mem_rdata >= src_a) ? WORD_ZERO : mem_rdata + WORD_ONE);
  endproperty
  a_increment: assert property (p_increment) else $error("wrapping increment wrong");

  property p_compare;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (state == ST_UPDATE) && (base == OP_CMP_STORE) && (mem_rdata != src_b) |-> mem_wdata == mem_rdata;
  endproperty
  a_compare: assert property (p_compare) else $error("compare-store changed word");

  property p_pair_addr;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    s_taken ##0 (issue_base == OP_PAIR_XCHG) |-> ##2 mem_we && (mem_waddr == $past(pair_target, 2));
  endproperty
  a_pair_addr: assert property (p_pair_addr) else $error("paired exchange address wrong");

  property p_rel_addr;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    s_taken ##0 (issue_base == OP_REL_XCHG) |-> ##2 mem_we && (mem_waddr == $past(rel_target, 2));
  endproperty
  a_rel_addr: assert property (p_rel_addr) else $error("relative exchange address wrong");
endmodule

//--- test/clause_sequencer_model.sv
// Clause sequencer model that presents one indexed issue at a time
`timescale 1ns/10ps
module clause_sequencer_model (
  // Clock and handshake
  input  wire logic                               clk_sys_in,
  input  wire logic                               ready_in,
  // Issue fields
  output logic                                    issue_valid_out,
  output logic      [local_share_pkg::SLOT_W-1:0] slot_out,
  output logic      [local_share_pkg::OPC_W-1:0]  opc_out,
  output logic      [local_share_pkg::SEL_W-1:0]  sel_out,
  output logic      [local_share_pkg::ADDR_W-1:0] a0_out,
  output logic      [local_share_pkg::ADDR_W-1:0] a1_out,
  output logic      [local_share_pkg::OFS_W-1:0]  ofs_out,
  output logic      [local_share_pkg::DATA_W-1:0] s1_out,
  output logic      [local_share_pkg::DATA_W-1:0] s2_out
);
  import local_share_pkg::*;
  initial {issue_valid_out, slot_out, opc_out, sel_out, a0_out, a1_out, ofs_out, s1_out, s2_out} = '0;
  // Hold the issue until an edge that sees ready, then invert the address and source lines
  task automatic send(input logic [SLOT_W-1:0] sl, input logic [OPC_W-1:0] op, input logic [SEL_W-1:0] sel,
                      input logic [ADDR_W-1:0] a0, input logic [ADDR_W-1:0] a1, input logic [OFS_W-1:0] o,
                      input logic [DATA_W-1:0] s1, input logic [DATA_W-1:0] s2);
    logic r;
    @(posedge clk_sys_in);
    issue_valid_out <= 1'b1;
    {slot_out, opc_out, sel_out, a0_out, a1_out, ofs_out, s1_out, s2_out} <= {sl, op, sel, a0, a1, o, s1, s2};
    do begin
      @(negedge clk_sys_in);
      r = ready_in;
      @(posedge clk_sys_in);
    end while (r !== 1'b1);
    issue_valid_out <= 1'b0;
    {a0_out, a1_out, s1_out, s2_out} <= ~{a0, a1, s1, s2};
  endtask
endmodule

//--- test/testbench.sv
// Self-checking bench for the local share atomic unit
`timescale 1ns/10ps
module testbench;
  import local_share_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rstn_in    = 1'b0;
  logic iv, ready_out, reject_out, qa_v, qb_v;
  logic [SLOT_W-1:0] sl;
  logic [OPC_W-1:0]  opc;
  logic [SEL_W-1:0]  sel;
  logic [ADDR_W-1:0] a0, a1, a, b;
  logic [OFS_W-1:0]  ofs, o;
  logic [DATA_W-1:0] s1r, s2r, qa_d, qb_d, w, s1, s2;
  logic [DATA_W+1:0] notes[$];
  logic [BASE_W-1:0] ops[17] = '{OP_SUB, OP_RSUB, OP_INC, OP_DEC, OP_MIN_INT, OP_MAX_INT, OP_MIN_UINT,
                                 OP_MAX_UINT, OP_MSKOR, OP_CMP_STORE, OP_ADD, OP_AND, OP_OR, OP_XOR,
                                 OP_XCHG, OP_BYTE_WRITE, OP_SHORT_WRITE};
  logic [BASE_W-1:0] pw[4] = '{OP_PAIR_WRITE, OP_REL_WRITE, OP_PAIR_XCHG, OP_REL_XCHG};
  int miscompares = 0;
  int checked     = 0;
  int cycles      = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  clause_sequencer_model u_clause_sequencer_model (.clk_sys_in(clk_sys_in), .ready_in(ready_out),
    .issue_valid_out(iv), .slot_out(sl), .opc_out(opc), .sel_out(sel), .a0_out(a0), .a1_out(a1),
    .ofs_out(ofs), .s1_out(s1r), .s2_out(s2r));
  local_share_atomic_unit u_local_share_atomic_unit (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .issue_valid_in(iv), .element_slot_in(sl), .arith_opcode_field_in(opc), .share_operation_select_in(sel),
    .addr_first_in(a0), .addr_second_in(a1), .index_offset_in(ofs), .src_first_in(s1r), .src_second_in(s2r),
    .ready_out(ready_out), .reject_out(reject_out), .return_queue_a_valid_out(qa_v),
    .return_queue_a_data_out(qa_d), .return_queue_b_valid_out(qb_v), .return_queue_b_data_out(qb_d));
  // Reference update of one stored word
  function automatic logic [DATA_W-1:0] upd(logic [BASE_W-1:0] op, logic [DATA_W-1:0] w, x, m);
    case (op)
      OP_SUB:      return w - x;
      OP_RSUB:     return x - w;
      OP_INC:      return (w >= x) ? WORD_ZERO : w + 1;
      OP_DEC:      return (w == 0 || w > x) ? x : w - 1;
      OP_MIN_INT:  return ($signed(w) < $signed(x)) ? w : x;
      OP_MAX_INT:  return ($signed(w) > $signed(x)) ? w : x;
      OP_MIN_UINT: return (w < x) ? w : x;
      OP_MAX_UINT: return (w > x) ? w : x;
      OP_MSKOR:    return (w & ~m) | x;
      OP_ADD:      return w + x;
      OP_AND:      return w & x;
      OP_OR:       return w | x;
      OP_XOR:      return w ^ x;
      OP_XCHG:     return x;
      OP_BYTE_WRITE:  return {24'h00_0000, x[7:0]};
      OP_SHORT_WRITE: return {16'h0000, x[15:0]};
      default:     return (w == m) ? x : w;
    endcase
  endfunction
  task automatic check(string name, logic [DATA_W+1:0] seen, logic [DATA_W+1:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic go(logic [SEL_W-1:0] s, logic [ADDR_W-1:0] x, y, logic [OFS_W-1:0] f, logic [DATA_W-1:0] d, e);
    u_clause_sequencer_model.send(SLOT_X, SHARE_IDX_OPC, s, x, y, f, d, e);
  endtask
  task automatic rd(logic [ADDR_W-1:0] x, logic [DATA_W-1:0] e);
    notes.push_back({2'd0, e});
    go({1'b1, OP_READ}, x, 10'h000, 6'h00, WORD_ZERO, WORD_ZERO);
  endtask
  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Oldest note against each result pulse
  always @(negedge clk_sys_in) begin
    if (qa_v === 1'b1) begin
      check("queue a", {2'd0, qa_d}, notes.size() ? notes.pop_front() : '1);
    end
    if (qb_v === 1'b1) check("queue b", {2'd1, qb_d}, notes.size() ? notes.pop_front() : '1);
    if (reject_out === 1'b1) check("reject", 34'h2_0000_0001, notes.size() ? notes.pop_front() : '1);
  end
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(10));
    repeat (20) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    // Atomic updates with zero, equal and random stored words; the equal case is non-returning
    foreach (ops[i]) for (int j = 0; j < 3; j++) begin
      a = $urandom; s1 = $urandom; w = (j == 0) ? WORD_ZERO : (j == 1) ? s1 : $urandom; s2 = (j == 1) ? w : $urandom;
      go({1'b0, OP_WRITE}, a, 10'h000, 6'h00, w, WORD_ZERO);
      if (j != 1) notes.push_back({2'd0, w});
      go({j != 1, ops[i]}, a, 10'h000, 6'h00, s1, s2);
      rd(a, upd(ops[i], w, s1, s2));
    end
    $display("test atomics done");
    // Half-word and byte reads with both signs, then dual, relative and read-then-write
    for (int j = 0; j < 2; j++) begin
      a = $urandom; w = $urandom; w[15] = j[0]; o = 1 + $urandom % 15; b = a + o; s1 = $urandom; s2 = $urandom;
      w[7] = ~j[0];
      go({1'b0, OP_WRITE}, a, 10'h000, 6'h00, w, WORD_ZERO);
      go({1'b0, OP_WRITE}, b, 10'h000, 6'h00, s1, WORD_ZERO);
      notes.push_back({2'd0, {{16{w[15]}}, w[15:0]}});
      go({1'b1, OP_SHORT_READ}, a, 10'h000, 6'h00, WORD_ZERO, WORD_ZERO);
      notes.push_back({2'd0, {16'h0000, w[15:0]}});
      notes.push_back({2'd0, {{24{w[7]}}, w[7:0]}});
      notes.push_back({2'd0, {24'h00_0000, w[7:0]}});
      for (int k = 0; k < 3; k++) begin
        go({1'b0, BASE_W'(OP_USHORT_READ + k)}, a, 10'h000, 6'h00, WORD_ZERO, WORD_ZERO);
      end
      notes.push_back({2'd0, w}); notes.push_back({2'd1, s1});
      go({1'b1, OP_DUAL_READ}, a, b, 6'h00, WORD_ZERO, WORD_ZERO);
      notes.push_back({2'd0, w}); notes.push_back({2'd1, s1});
      go({1'b1, OP_REL_READ}, a, 10'h000, o, WORD_ZERO, WORD_ZERO);
      notes.push_back({2'd0, w});
      go({1'b1, OP_READ_WRITE}, a, b, 6'h00, s2, WORD_ZERO);
      rd(b, s2);
    end
    $display("test reads done");
    // Paired and relative writes and exchanges at the derived second address
    foreach (pw[k]) begin
      a = $urandom; w = $urandom; o = 1 + $urandom % 15; s1 = $urandom; s2 = $urandom;
      b = a + ((k % 2 == 0) ? (ADDR_W'(o) << PAIR_SHIFT) : ADDR_W'(o));
      go({1'b0, OP_WRITE}, a, 10'h000, 6'h00, w, WORD_ZERO);
      if (k > 1) notes.push_back({2'd0, w});
      go({1'b0, pw[k]}, a, 10'h000, o, s1, s2);
      rd(a, s1);
      rd(b, s2);
    end
    $display("test pairs done");
    // Illegal slot, opcode and ordered allocate are refused without a write
    for (int j = 0; j < 3; j++) begin
      notes.push_back({2'd2, 32'h0000_0001});
      u_clause_sequencer_model.send((j == 0) ? 3'h1 : SLOT_X, (j == 1) ? 5'h10 : SHARE_IDX_OPC,
        (j == 2) ? {1'b1, OP_ORDER_ALLOC} : {1'b0, OP_WRITE}, a, 10'h000, 6'h00, ~s1, WORD_ZERO);
    end
    rd(a, s1);
    $display("test refusals done");
    repeat (10) @(posedge clk_sys_in);
    check("notes left", 34'(notes.size()), 34'h0_0000_0000);
    end_sim();
  end
endmodule
